//--- verilog/vme_decode_pkg.sv
/*
 * Shared constants for the slave address decoder: modifier codes,
 * register offsets, field positions and reset values.
 * Assumes a single 100 MHz module clock.
 */
package vme_decode_pkg;
	// accepted modifier codes
	localparam logic [5:0] AM_A24_SUP_BLT = 6'h3F;
	localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
	localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
	localparam logic [5:0] AM_A24_USR_BLT = 6'h3B;
	localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
	localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
	localparam logic [5:0] AM_CSR = 6'h2F;
	localparam logic [5:0] AM_A32_SUP_BLT = 6'h0F;
	localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
	localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
	localparam logic [5:0] AM_A32_USR_BLT = 6'h0B;
	localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
	localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
	////////////////////////////////////////////////////////////////////
	// register offsets within the 64 KB window
	localparam logic [15:0] OFF_SLOT = 16'h1002;
	localparam logic [15:0] OFF_CTRL_SET = 16'h1006;
	localparam logic [15:0] OFF_CTRL_CLR = 16'h1008;
	localparam logic [15:0] OFF_BASE_HIGH = 16'h1030;
	localparam logic [15:0] OFF_BASE_LOW = 16'h1032;
	// first offset above the readout buffer
	localparam logic [15:0] OUTBUF_END = 16'h1000;
	// control bit selecting programmable base
	localparam int BASE_SRC_BIT = 4;
	localparam logic BASE_SRC_RESET = 1'b0;
	localparam logic [7:0] BASE_REG_RESET = 8'h00;
	localparam logic [4:0] SLOT_RESET = 5'h00;
	// reset capture of slot lines after synchroniser fills
	localparam logic [1:0] CAP_TAKE = 2'h2;
	localparam logic [1:0] CAP_DONE = 2'h3;
	////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		SPACE_NONE,
		SPACE_A24,
		SPACE_A32,
		SPACE_CSR
	} space_e;
	typedef enum logic [1:0] {
		XFER_SINGLE,
		XFER_BLT,
		XFER_MBLT,
		XFER_CSR
	} xfer_e;
	typedef enum logic {
		CYC_IDLE,
		CYC_ACK
	} cyc_e;
endpackage

//--- verilog/vme_slave_address_decode.sv
/*
 * Address decode front end of a bus slave: modifier check, base compare
 * against switches or programmable registers, slot-position decode, and
 * the few registers that steer it.
 * Assumes all bus and backplane inputs are asynchronous to clock; each
 * passes two flip-flops. Address, modifier and data are stable while
 * the strobes are asserted, as the bus guarantees.
 */
`timescale 1ns/1ps
module vme_slave_address_decode (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bus cycle pins
	input wire logic as_n,
	input wire logic ds_n,
	input wire logic write_n,
	input wire logic [5:0] am,
	input wire logic [31:0] addr,
	input wire logic [15:0] data_in,
	// board straps and backplane
	input wire logic [15:0] base_switch,
	input wire logic [4:0] slot_id_lines,
	input wire logic aux_backplane_connector,
	// decode results
	output logic hit,
	output logic addr_a32,
	output logic [1:0] xfer_kind,
	output logic [15:0] reg_offset,
	output logic [4:0] slot_position_code,
	// bus answer
	output logic dtack_n,
	output logic [15:0] data_out,
	output logic data_oe
);
	typedef struct packed {
		vme_decode_pkg::cyc_e cyc;
		logic [1:0] cap_cnt;
		logic [4:0] slot_pos;
		logic [4:0] slot_tag;
		logic base_src;
		logic [7:0] base_high;
		logic [7:0] base_low;
		logic [1:0] as_s;
		logic [1:0] ds_s;
		logic [1:0] wr_s;
		logic [1:0] aux_s;
		logic [5:0] am_s1;
		logic [5:0] am_s2;
		logic [31:0] a_s1;
		logic [31:0] a_s2;
		logic [15:0] d_s1;
		logic [15:0] d_s2;
		logic [15:0] sw_s1;
		logic [15:0] sw_s2;
		logic [4:0] sl_s1;
		logic [4:0] sl_s2;
		logic hit;
		logic a32;
		vme_decode_pkg::xfer_e kind;
		logic [15:0] offset;
		logic dtack_n;
		logic [15:0] rd_data;
		logic data_oe;
	} state_s;

	state_s st;
	state_s next_st;
	vme_decode_pkg::space_e space;
	logic [15:0] base;
	logic cycle_on;
	logic match;

	////////////////////////////////////////////////////////////////////
	// modifier to address space
	function automatic vme_decode_pkg::space_e am_space(
		input logic [5:0] code
	);
		case (code)
			vme_decode_pkg::AM_A24_SUP_BLT,
			vme_decode_pkg::AM_A24_SUP_DATA,
			vme_decode_pkg::AM_A24_SUP_MBLT,
			vme_decode_pkg::AM_A24_USR_BLT,
			vme_decode_pkg::AM_A24_USR_DATA,
			vme_decode_pkg::AM_A24_USR_MBLT:
				return vme_decode_pkg::SPACE_A24;
			vme_decode_pkg::AM_A32_SUP_BLT,
			vme_decode_pkg::AM_A32_SUP_DATA,
			vme_decode_pkg::AM_A32_SUP_MBLT,
			vme_decode_pkg::AM_A32_USR_BLT,
			vme_decode_pkg::AM_A32_USR_DATA,
			vme_decode_pkg::AM_A32_USR_MBLT:
				return vme_decode_pkg::SPACE_A32;
			vme_decode_pkg::AM_CSR:
				return vme_decode_pkg::SPACE_CSR;
			default:
				return vme_decode_pkg::SPACE_NONE;
		endcase
	endfunction

	// modifier to transfer type
	function automatic vme_decode_pkg::xfer_e am_kind(
		input logic [5:0] code
	);
		case (code)
			vme_decode_pkg::AM_A24_SUP_BLT,
			vme_decode_pkg::AM_A24_USR_BLT,
			vme_decode_pkg::AM_A32_SUP_BLT,
			vme_decode_pkg::AM_A32_USR_BLT:
				return vme_decode_pkg::XFER_BLT;
			vme_decode_pkg::AM_A24_SUP_MBLT,
			vme_decode_pkg::AM_A24_USR_MBLT,
			vme_decode_pkg::AM_A32_SUP_MBLT,
			vme_decode_pkg::AM_A32_USR_MBLT:
				return vme_decode_pkg::XFER_MBLT;
			vme_decode_pkg::AM_CSR:
				return vme_decode_pkg::XFER_CSR;
			default:
				return vme_decode_pkg::XFER_SINGLE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.as_s = {st.as_s[0], as_n};
		next_st.ds_s = {st.ds_s[0], ds_n};
		next_st.wr_s = {st.wr_s[0], write_n};
		next_st.aux_s = {st.aux_s[0], aux_backplane_connector};
		next_st.am_s1 = am;
		next_st.am_s2 = st.am_s1;
		next_st.a_s1 = addr;
		next_st.a_s2 = st.a_s1;
		next_st.d_s1 = data_in;
		next_st.d_s2 = st.d_s1;
		next_st.sw_s1 = base_switch;
		next_st.sw_s2 = st.sw_s1;
		next_st.sl_s1 = slot_id_lines;
		next_st.sl_s2 = st.sl_s1;

		if (st.cap_cnt != vme_decode_pkg::CAP_DONE) begin
			next_st.cap_cnt = st.cap_cnt + 2'h1;
			if (st.cap_cnt == vme_decode_pkg::CAP_TAKE) begin
				next_st.slot_pos = st.sl_s2;
			end
		end

		cycle_on = !st.as_s[1] && !st.ds_s[1];
		space = am_space(st.am_s2);
		base = st.base_src ? {st.base_high, st.base_low} : st.sw_s2;
		// compare width by space, 64 KB granularity
		case (space)
			vme_decode_pkg::SPACE_A24:
				match = st.a_s2[23:16] == base[7:0];
			vme_decode_pkg::SPACE_A32:
				match = st.a_s2[31:16] == base;
			vme_decode_pkg::SPACE_CSR:
				match = st.aux_s[1]
					&& st.cap_cnt == vme_decode_pkg::CAP_DONE
					&& st.a_s2[23:19] == st.slot_pos
					&& st.a_s2[18:16] == 3'h0
					&& st.a_s2[15:0] >= vme_decode_pkg::OUTBUF_END;
			default:
				match = 1'b0;
		endcase

		case (st.cyc)
			vme_decode_pkg::CYC_IDLE: begin
				if (cycle_on && match) begin
					next_st.cyc = vme_decode_pkg::CYC_ACK;
					next_st.hit = 1'b1;
					next_st.a32 = space == vme_decode_pkg::SPACE_A32;
					next_st.kind = am_kind(st.am_s2);
					next_st.offset = st.a_s2[15:0];
					next_st.dtack_n = 1'b0;
					if (!st.wr_s[1]) begin
						case (st.a_s2[15:0])
							vme_decode_pkg::OFF_CTRL_SET:
								if (st.d_s2[vme_decode_pkg::BASE_SRC_BIT]) begin
									next_st.base_src = 1'b1;
								end
							vme_decode_pkg::OFF_CTRL_CLR:
								if (st.d_s2[vme_decode_pkg::BASE_SRC_BIT]) begin
									next_st.base_src = 1'b0;
								end
							vme_decode_pkg::OFF_BASE_HIGH:
								next_st.base_high = st.d_s2[7:0];
							vme_decode_pkg::OFF_BASE_LOW:
								next_st.base_low = st.d_s2[7:0];
							vme_decode_pkg::OFF_SLOT:
								if (!st.aux_s[1]) begin
									next_st.slot_tag = st.d_s2[4:0];
								end
							default: ;
						endcase
					end else begin
						next_st.data_oe = 1'b1;
						case (st.a_s2[15:0])
							vme_decode_pkg::OFF_CTRL_SET,
							vme_decode_pkg::OFF_CTRL_CLR: begin
								next_st.rd_data = 16'h0000;
								next_st.rd_data[vme_decode_pkg::BASE_SRC_BIT] =
									st.base_src;
							end
							vme_decode_pkg::OFF_BASE_HIGH:
								next_st.rd_data = {8'h00, st.base_high};
							vme_decode_pkg::OFF_BASE_LOW:
								next_st.rd_data = {8'h00, st.base_low};
							vme_decode_pkg::OFF_SLOT:
								next_st.rd_data = {11'h000, st.aux_s[1] ?
									st.slot_pos : st.slot_tag};
							default:
								next_st.rd_data = 16'h0000;
						endcase
					end
				end
			end
			vme_decode_pkg::CYC_ACK: begin
				if (st.ds_s[1]) begin
					next_st.cyc = vme_decode_pkg::CYC_IDLE;
					next_st.hit = 1'b0;
					next_st.dtack_n = 1'b1;
					next_st.data_oe = 1'b0;
				end
			end
			default:
				next_st.cyc = vme_decode_pkg::CYC_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cyc <= vme_decode_pkg::CYC_IDLE;
			st.slot_pos <= vme_decode_pkg::SLOT_RESET;
			st.slot_tag <= vme_decode_pkg::SLOT_RESET;
			st.base_src <= vme_decode_pkg::BASE_SRC_RESET;
			st.base_high <= vme_decode_pkg::BASE_REG_RESET;
			st.base_low <= vme_decode_pkg::BASE_REG_RESET;
			st.as_s <= 2'h3;
			st.ds_s <= 2'h3;
			st.wr_s <= 2'h3;
			st.dtack_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign hit = st.hit;
	assign addr_a32 = st.a32;
	assign xfer_kind = st.kind;
	assign reg_offset = st.offset;
	assign slot_position_code = st.slot_pos;
	assign dtack_n = st.dtack_n;
	assign data_out = st.rd_data;
	assign data_oe = st.data_oe;

	////////////////////////////////////////////////////////////////////
	a_a24_answer: assert property (@(posedge clock) disable iff (!rst_n)
		st.cyc == vme_decode_pkg::CYC_IDLE && cycle_on
		&& space == vme_decode_pkg::SPACE_A24 && st.a_s2[23:16] == base[7:0]
		|=> !dtack_n && hit && !addr_a32)
		else $error("a24 cycle at base not answered");
	a_a32_answer: assert property (@(posedge clock) disable iff (!rst_n)
		st.cyc == vme_decode_pkg::CYC_IDLE && cycle_on
		&& space == vme_decode_pkg::SPACE_A32 && st.a_s2[31:16] == base
		|=> !dtack_n ##0 addr_a32 ##0 reg_offset == $past(st.a_s2[15:0]))
		else $error("a32 cycle at base not answered");
	a_csr_kind: assert property (@(posedge clock) disable iff (!rst_n)
		st.cyc == vme_decode_pkg::CYC_IDLE && cycle_on && match
		&& st.am_s2 == vme_decode_pkg::AM_CSR
		|=> xfer_kind == vme_decode_pkg::XFER_CSR)
		else $error("csr access mistyped");
	a_no_answer: assert property (@(posedge clock) disable iff (!rst_n)
		st.cyc == vme_decode_pkg::CYC_IDLE && (!cycle_on || !match)
		|=> dtack_n && !hit)
		else $error("answered an unmatched cycle");
	a_switch_base: assert property (@(posedge clock) disable iff (!rst_n)
		!st.base_src && space == vme_decode_pkg::SPACE_A32
		&& st.a_s2[31:16] != st.sw_s2 |-> !match)
		else $error("matched away from switch base");
	a_reg_base: assert property (@(posedge clock) disable iff (!rst_n)
		st.base_src && space == vme_decode_pkg::SPACE_A32
		&& st.a_s2[31:16] == {st.base_high, st.base_low} |-> match)
		else $error("register base not matched");
	a_set_source: assert property (@(posedge clock) disable iff (!rst_n)
		st.cyc == vme_decode_pkg::CYC_IDLE && cycle_on && match
		&& !st.wr_s[1] && st.a_s2[15:0] == vme_decode_pkg::OFF_CTRL_SET
		&& st.d_s2[vme_decode_pkg::BASE_SRC_BIT] |=> st.base_src)
		else $error("base source not set");
	a_reset_source: assert property (@(posedge clock) disable iff (!rst_n)
		st.cap_cnt == 2'h0 |-> !st.base_src)
		else $error("base source not zero after reset");
	a_geo_no_aux: assert property (@(posedge clock) disable iff (!rst_n)
		!st.aux_s[1] && space == vme_decode_pkg::SPACE_CSR |-> !match)
		else $error("slot decode without slot lines");
	a_geo_fields: assert property (@(posedge clock) disable iff (!rst_n)
		space == vme_decode_pkg::SPACE_CSR
		&& (st.a_s2[23:19] != st.slot_pos || st.a_s2[18:16] != 3'h0)
		|-> !match)
		else $error("slot decode field mismatch accepted");
	a_outbuf_hidden: assert property (@(posedge clock) disable iff (!rst_n)
		space == vme_decode_pkg::SPACE_CSR
		&& st.a_s2[15:0] < vme_decode_pkg::OUTBUF_END |-> !match)
		else $error("readout buffer reached by slot decode");
	a_slot_held: assert property (@(posedge clock) disable iff (!rst_n)
		st.cap_cnt == vme_decode_pkg::CAP_DONE |=> $stable(st.slot_pos))
		else $error("slot code changed after capture");
endmodule // vme_slave_address_decode

//--- test/vme_master_model.sv
/*
 * Bus master model: runs one D16 cycle at a time on the slave's pins.
 * Assumes the slave answers with dtack_n, data_out and data_oe.
 */
`timescale 1ns/1ps
module vme_master_model (
	// clock
	input wire logic clock,
	// pins toward the slave
	output logic as_n,
	output logic ds_n,
	output logic write_n,
	output logic [5:0] am,
	output logic [31:0] addr,
	output logic [15:0] data_in,
	// slave answer
	input wire logic dtack_n,
	input wire logic [15:0] data_out,
	input wire logic data_oe
);
	initial begin
		as_n = 1'b1;
		ds_n = 1'b1;
		write_n = 1'b1;
		am = 6'h00;
		addr = 32'h0000_0000;
		data_in = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	// strobes held until the answer, bounded wait
	task automatic bus_cycle(input logic [5:0] code, input logic [31:0] a,
		input logic wr, input logic [15:0] wd, output logic ack,
		output logic [15:0] rd);
		ack = 1'b0;
		rd = 16'h0000;
		@(posedge clock);
		#1;
		am = code;
		addr = a;
		write_n = ~wr;
		data_in = wd;
		as_n = 1'b0;
		ds_n = 1'b0;
		for (int i = 0; i < 8 && !ack; i++) begin
			@(posedge clock);
			#1;
			ack = (dtack_n === 1'b0);
		end
		// hold strobes through the edge that samples the answer
		if (ack) begin
			@(posedge clock);
			#1;
			if (data_oe === 1'b1)
				rd = data_out;
		end
	endtask
	// released lines show inverted values, not stale ones
	task automatic bus_release(output logic ok);
		ok = 1'b0;
		ds_n = 1'b1;
		as_n = 1'b1;
		write_n = 1'b1;
		am = ~am;
		addr = ~addr;
		data_in = ~data_in;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clock);
			#1;
			ok = (dtack_n === 1'b1);
		end
		repeat (3) @(posedge clock);
	endtask
endmodule // vme_master_model

//--- test/vme_slave_address_decode_tb_top.sv
/*
 * Testbench for the slave address decoder: modifier table, base
 * source, slot decode and refusals, through the master model.
 * Assumes a 100 MHz clock and the design's own two-flop synchronisers.
 */
`timescale 1ns/1ps
module vme_slave_address_decode_tb_top;
	logic clock, rst_n, as_n, ds_n, write_n, aux, hit, a32, dtack_n, oe;
	logic [5:0] am;
	logic [31:0] addr;
	logic [15:0] data_in, base_switch, reg_offset, data_out, rd;
	logic [4:0] slot_id_lines, slot_code;
	logic [1:0] xfer_kind, kind;
	logic ack, ok, was_a32;
	int n_errors = 0;
	int checked = 0;
	logic [5:0] codes [12] = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38,
		6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
	logic [1:0] kinds [3] = '{2'h1, 2'h0, 2'h2};
	initial clock = 1'b0;
	always #5 clock = ~clock;
	vme_slave_address_decode uut (.clock(clock), .rst_n(rst_n),
		.as_n(as_n), .ds_n(ds_n), .write_n(write_n), .am(am), .addr(addr),
		.data_in(data_in), .base_switch(base_switch),
		.slot_id_lines(slot_id_lines), .aux_backplane_connector(aux),
		.hit(hit), .addr_a32(a32), .xfer_kind(xfer_kind),
		.reg_offset(reg_offset), .slot_position_code(slot_code),
		.dtack_n(dtack_n), .data_out(data_out), .data_oe(oe));
	vme_master_model mst (.clock(clock), .as_n(as_n), .ds_n(ds_n),
		.write_n(write_n), .am(am), .addr(addr), .data_in(data_in),
		.dtack_n(dtack_n), .data_out(data_out), .data_oe(oe));
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic access(input logic [5:0] code, input logic [31:0] a,
		input logic wr, input logic [15:0] wd, input logic exp_ack);
		mst.bus_cycle(code, a, wr, wd, ack, rd);
		check_flag(ack, exp_ack);
		if (ack) begin
			kind = xfer_kind;
			was_a32 = a32;
			check_flag(hit, 1'b1);
			check_val(reg_offset, a[15:0]);
			check_flag(oe, !wr);
		end
		mst.bus_release(ok);
		if (!ok) begin
			n_errors++;
			final_report();
		end
	endtask
	task automatic do_reset(input logic strap, input logic [4:0] slot);
		#1;
		aux = strap;
		slot_id_lines = slot;
		rst_n = 1'b0;
		repeat (6) @(posedge clock);
		#1;
		rst_n = 1'b1;
		repeat (6) @(posedge clock);
		#1;
		check_flag(dtack_n, 1'b1);
		check_flag(hit, 1'b0);
		check_flag(oe, 1'b0);
		check_val({11'h000, slot_code}, {11'h000, slot});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		base_switch = 16'hCC11;
		slot_id_lines = 5'h05;
		aux = 1'b1;
		do_reset(1'b1, 5'h05);
		access(6'h0D, 32'hCC111006, 1'b0, 16'h0000, 1'b1);
		check_val(rd & 16'h0010, 16'h0000);
		$display("test reset_defaults done");
		for (int i = 0; i < 12; i++) begin
			access(codes[i], (i < 6) ? 32'h00111006 : 32'hCC111006, 1'b0,
				16'h0000, 1'b1);
			check_val({14'h0000, kind}, {14'h0000, kinds[i % 3]});
			check_flag(was_a32, i >= 6);
		end
		$display("test modifier_table done");
		access(6'h3E, 32'h00111006, 1'b0, 16'h0000, 1'b0);
		access(6'h0E, 32'hCC111006, 1'b0, 16'h0000, 1'b0);
		access(6'h0D, 32'hCC121006, 1'b0, 16'h0000, 1'b0);
		access(6'h39, 32'h00121006, 1'b0, 16'h0000, 1'b0);
		$display("test refusals done");
		check_val({11'h000, slot_code}, 16'h0005);
		access(6'h2F, 32'h00281006, 1'b1, 16'h0010, 1'b1);
		check_val({14'h0000, kind}, 16'h0003);
		access(6'h2F, 32'h00281030, 1'b1, 16'h00AB, 1'b1);
		access(6'h2F, 32'h00281032, 1'b1, 16'h00CD, 1'b1);
		access(6'h2F, 32'h00281030, 1'b0, 16'h0000, 1'b1);
		check_val(rd, 16'h00AB);
		access(6'h2F, 32'h00281032, 1'b0, 16'h0000, 1'b1);
		check_val(rd, 16'h00CD);
		access(6'h2F, 32'h00281002, 1'b1, 16'h001F, 1'b1);
		access(6'h2F, 32'h00281002, 1'b0, 16'h0000, 1'b1);
		check_val(rd, 16'h0005);
		access(6'h0D, 32'hABCD1006, 1'b0, 16'h0000, 1'b1);
		check_val(rd & 16'h0010, 16'h0010);
		access(6'h0D, 32'hCC111006, 1'b0, 16'h0000, 1'b0);
		access(6'h39, 32'h00CD1006, 1'b0, 16'h0000, 1'b1);
		access(6'h39, 32'h00281006, 1'b0, 16'h0000, 1'b0);
		access(6'h2F, 32'hFF281006, 1'b0, 16'h0000, 1'b1);
		access(6'h2F, 32'h002C1006, 1'b0, 16'h0000, 1'b0);
		access(6'h2F, 32'h00280010, 1'b0, 16'h0000, 1'b0);
		access(6'h2F, 32'h00281008, 1'b1, 16'h0010, 1'b1);
		access(6'h0D, 32'hCC111006, 1'b0, 16'h0000, 1'b1);
		check_val(rd & 16'h0010, 16'h0000);
		$display("test slot_and_base done");
		do_reset(1'b0, 5'h0A);
		access(6'h2F, 32'h00501006, 1'b0, 16'h0000, 1'b0);
		access(6'h0D, 32'hCC111002, 1'b1, 16'h0009, 1'b1);
		access(6'h0D, 32'hCC111002, 1'b0, 16'h0000, 1'b1);
		check_val(rd & 16'h001F, 16'h0009);
		access(6'h2F, 32'h00481006, 1'b0, 16'h0000, 1'b0);
		$display("test no_slot_lines done");
		final_report();
	end
endmodule // vme_slave_address_decode_tb_top
